// file: sfr_consts.svh
// constants of the fault readout: word layout, reset values, timings
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// ****************************************************************
// word addresses carried in bits 15..12
// ****************************************************************
`define SFR_ADDR_INIT1 4'h0
`define SFR_ADDR_QUICK 4'h1
`define SFR_ADDR_CH_FIRST 4'h2
`define SFR_ADDR_CH_LAST 4'h6

// ****************************************************************
// fields of the init-1 word written by the host
// ****************************************************************
`define SFR_SOA_MSB 3
`define SFR_SOA_LSB 0
`define SFR_PERSIST_BIT 4

// ****************************************************************
// fields of the readout words
// ****************************************************************
`define SFR_ADDR_MSB 15
`define SFR_ADDR_LSB 12
`define SFR_FM_BIT 11
`define SFR_DSF_BIT 10
`define SFR_OVERLOAD_SUMMARY_FLAG_BIT 9
`define SFR_OLF_BIT 8
`define SFR_CPF_BIT 7
`define SFR_RCF_BIT 6
`define SFR_CLOCK_FAIL_FLAG_BIT 5
`define SFR_OTS_BIT 6
`define SFR_OTW_BIT 5
`define SFR_OC_MSB 4
`define SFR_OC_LSB 2
`define SFR_OLON_BIT 1
`define SFR_OLOFF_BIT 0

// ****************************************************************
// reset values
// ****************************************************************
`define SFR_SEL_RST 4'h1
`define SFR_PERSIST_RST 1'b0
`define SFR_RCF_RST 1'b1

// ****************************************************************
// timing
// ****************************************************************
`define SFR_FRAME_BITS 16
`define SFR_CORE_MHZ 200
`define SFR_T_OLOFF_DGL_NS 3300
`define SFR_OLOFF_DGL_CYC \
    ((`SFR_T_OLOFF_DGL_NS * `SFR_CORE_MHZ + 999) / 1000)
`define SFR_T_OLON_SHORT_US 64
`define SFR_OLON_SHORT_CYC (`SFR_T_OLON_SHORT_US * `SFR_CORE_MHZ)
`define SFR_T_OLON_LONG_US 2000
`define SFR_OLON_LONG_CYC (`SFR_T_OLON_LONG_US * `SFR_CORE_MHZ)
`define SFR_T_OLOFF_US 1200
`define SFR_OLOFF_CYC (`SFR_T_OLOFF_US * `SFR_CORE_MHZ)
`define SFR_T_LED_US 2000
`define SFR_LED_CYC (`SFR_T_LED_US * `SFR_CORE_MHZ)

`endif

// file: sfr_pkg.sv
// types of the fault readout block
package sfr_pkg;

    typedef enum logic {SFR_LED_IDLE, SFR_LED_RUN} sfr_led_t;

    typedef struct packed {
        logic [15:0] shift;
        logic [15:0] rx;
        logic tgl;
    } sfr_link_t;

    typedef struct packed {
        logic [72:0] s1;
        logic [72:0] s2;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_seen;
        logic [3:0] sel;
        logic persist;
        logic registers_cleared_flag;
        logic [4:0] ots;
        logic [4:0] otw;
        logic [4:0] olon;
        logic [4:0] oloff;
        logic [4:0][2:0] oc;
        logic [4:0][2:0] oc_prev;
        logic [4:0][18:0] on_cnt;
        logic [4:0][17:0] off_cnt;
        logic [4:0][9:0] dgl_cnt;
        logic [4:0] off_run;
        logic [4:0] start_prev;
        sfr_led_t led_st;
        logic [18:0] led_cnt;
        logic trig_prev;
        logic [15:0] tx;
    } sfr_core_t;

endpackage : sfr_pkg

// file: sfr_spi_link.sv
// serial link shifter running on the host's serial clock
`timescale 1ns/1ps
`include "sfr_consts.svh"

module sfr_spi_link (
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_rst_n,
    input wire logic i_sdi,
    input wire logic [15:0] i_tx_word,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic [15:0] o_rx_word,
    output logic o_frame_tgl
);
    import sfr_pkg::*;

    sfr_link_t st_q;
    sfr_link_t st_d;
    logic [4:0] bit_cnt_q;

    // ****************************************************************
    // bit counter, cleared while the frame select is inactive
    // ****************************************************************
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_cnt_q <= 5'h0;
        end else if (bit_cnt_q != 5'(`SFR_FRAME_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 5'h1;
        end
    end

    // ****************************************************************
    // shift in; a complete 16-bit frame flips the toggle
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        if (bit_cnt_q != 5'(`SFR_FRAME_BITS)) begin
            st_d.shift = {st_q.shift[14:0], i_sdi};
        end
        if (bit_cnt_q == 5'(`SFR_FRAME_BITS - 1)) begin
            st_d.rx = {st_q.shift[14:0], i_sdi};
            st_d.tgl = ~st_q.tgl;
        end
    end

    always_ff @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // word is held steady by the core for the whole frame
    assign o_sdo = (bit_cnt_q[4] == 1'b0) ?
        i_tx_word[4'hf - bit_cnt_q[3:0]] : 1'b0; // [RULE_03]
    assign o_sdo_oe = ~i_cs_n;
    assign o_rx_word = st_q.rx;
    assign o_frame_tgl = st_q.tgl;

endmodule : sfr_spi_link

// file: sfr_fault_readout.sv
// fault and diagnostic readout of a five-channel switch over serial link
// Function
// (RULE_01) output level bit follows half-supply comparator live
// (RULE_02) level bits undefined while undervoltage is set
// (RULE_03) address field selects the word shifted out
// (RULE_04) persist off: one read, then back to quick
// (RULE_05) persist on: address holds until rewritten
// (RULE_06) address zero gives quick word, top 0001
// (RULE_07) fail-mode flag at bit 11 of every word
// (RULE_08) summary flags clear when all sources cleared
// (RULE_09) device flag ORs six device fault flags
// (RULE_10) overload flag ORs overcurrent and shutdown flags
// (RULE_11) registers-cleared flag set after register reset
// (RULE_12) quick word holds pump and clock fail
// (RULE_13) channel quick flag ORs all channel faults
// (RULE_14) host reads channel word for fault detail
// (RULE_15) channel word field layout, bit 7 reserved
// (RULE_16) newest overcurrent code overwrites an unread one
// (RULE_17) deglitch 3.3 us off, 64 us/2 ms on
// (RULE_18) off-state open-load window lasts 1.2 ms
// (RULE_19) LED full-duty detection ends within 2.0 ms
// (RULE_20) host keeps PWM duty above open-load minimum
// (RULE_21) channel read clears open-load once condition gone
// (RULE_22) top nibble of each word is address
`timescale 1ns/1ps
`include "sfr_consts.svh"

module sfr_fault_readout #(
    parameter logic [18:0] OLON_SHORT_CYC = 19'(`SFR_OLON_SHORT_CYC),
    parameter logic [18:0] OLON_LONG_CYC = 19'(`SFR_OLON_LONG_CYC),
    parameter logic [17:0] OLOFF_CYC = 18'(`SFR_OLOFF_CYC),
    parameter logic [18:0] LED_CYC = 19'(`SFR_LED_CYC)
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic I_SDI,
    output logic O_SDO,
    output logic O_SDO_OE,
    input wire logic I_FAIL_MODE,
    input wire logic I_UNDERVOLT,
    input wire logic I_OVERVOLT,
    input wire logic I_PUMP_FAULT,
    input wire logic I_CLOCK_FAIL,
    input wire logic I_TEST_ACTIVE,
    input wire logic [4:0] I_OVERTEMP_SHUTDOWN,
    input wire logic [4:0] I_OVERTEMP_WARN,
    input wire logic [14:0] I_OC_CODE,
    input wire logic [4:0] I_OPEN_ON_RAW,
    input wire logic [4:0] I_OUTPUT_ON,
    input wire logic [4:0] I_OPEN_ON_DEGLITCH_SEL,
    input wire logic [4:0] I_OPEN_OFF_START,
    input wire logic [4:0] I_OFF_CURRENT_REACHED,
    input wire logic [4:0] I_LED_OPEN_DETECT,
    input wire logic [4:0] I_LED_CMP,
    input wire logic I_LED_TRIGGER,
    input wire logic [4:0] I_HALF_SUPPLY_CMP,
    output logic [4:0] O_OUTPUT_LEVEL,
    output logic [4:0] O_OPEN_OFF_ACTIVE
);
    import sfr_pkg::*;

    sfr_core_t q;
    sfr_core_t d;

    logic cs_s, trig_s, tm_s, clock_fail_flag_s, cp_s, ov_s, uv_s, fm_s;
    logic [4:0] half_s, ledcmp_s, leden_s, reached_s, start_s;
    logic [4:0] dglsel_s, on_s, olraw_s, otw_s, ots_s;
    logic [14:0] oc_s;
    logic [15:0] rx_word;
    logic frame_tgl;
    logic frame_done;
    logic init_wr;
    logic device_summary_flag, overload_summary_flag, openload_summary_flag;
    logic [4:0] qsf;
    logic [4:0] clr;
    logic [4:0] oc_new;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic chan_any(input logic [2:0] oc,
                                      input logic ots, input logic otw,
                                      input logic olon,
                                      input logic oloff);
        chan_any = (|oc) | ots | otw | olon | oloff;
    endfunction : chan_any

    function automatic logic [15:0] chan_word(input logic [3:0] addr,
                                              input logic [3:0] hdr,
                                              input logic ots,
                                              input logic otw,
                                              input logic [2:0] oc,
                                              input logic olon,
                                              input logic oloff);
        chan_word = {addr, hdr, 1'b0, ots, otw, oc, olon, oloff};
    endfunction : chan_word

    // ****************************************************************
    // serial link on its own clock
    // ****************************************************************
    sfr_spi_link u_link (
        .i_sclk(I_SCLK),
        .i_cs_n(I_CS_N),
        .i_rst_n(I_RST_N),
        .i_sdi(I_SDI),
        .i_tx_word(q.tx),
        .o_sdo(O_SDO),
        .o_sdo_oe(O_SDO_OE),
        .o_rx_word(rx_word),
        .o_frame_tgl(frame_tgl)
    );

    // ****************************************************************
    // synchronised inputs
    // ****************************************************************
    assign {cs_s, trig_s, tm_s, clock_fail_flag_s, cp_s, ov_s, uv_s, fm_s,
            half_s, ledcmp_s, leden_s, reached_s, start_s, dglsel_s,
            on_s, olraw_s, oc_s, otw_s, ots_s} = q.s2;

    assign frame_done = q.tgl_s2 ^ q.tgl_seen;
    assign init_wr = rx_word[`SFR_ADDR_MSB:`SFR_ADDR_LSB] == `SFR_ADDR_INIT1;

    // ****************************************************************
    // summary flags
    // ****************************************************************
    assign device_summary_flag = q.registers_cleared_flag | uv_s | ov_s | cp_s | clock_fail_flag_s | tm_s; // [RULE_09]

    always_comb begin
        overload_summary_flag = 1'b0;
        openload_summary_flag = 1'b0;
        for (int c = 0; c < 5; c++) begin
            overload_summary_flag = overload_summary_flag | (|q.oc[c]) | q.ots[c]; // [RULE_10]
            openload_summary_flag = openload_summary_flag | q.olon[c] | q.oloff[c];
            qsf[c] = chan_any(q.oc[c], q.ots[c], q.otw[c], q.olon[c],
                              q.oloff[c]); // [RULE_13]
            clr[c] = frame_done &&
                (q.sel == `SFR_ADDR_CH_FIRST + 4'(c)); // [RULE_21]
            oc_new[c] = (oc_s[3*c +: 3] != 3'h0) &&
                (oc_s[3*c +: 3] != q.oc_prev[c]);
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.s1 = {I_CS_N, I_LED_TRIGGER, I_TEST_ACTIVE, I_CLOCK_FAIL,
                I_PUMP_FAULT, I_OVERVOLT, I_UNDERVOLT, I_FAIL_MODE,
                I_HALF_SUPPLY_CMP, I_LED_CMP, I_LED_OPEN_DETECT,
                I_OFF_CURRENT_REACHED, I_OPEN_OFF_START,
                I_OPEN_ON_DEGLITCH_SEL, I_OUTPUT_ON, I_OPEN_ON_RAW,
                I_OC_CODE, I_OVERTEMP_WARN, I_OVERTEMP_SHUTDOWN};
        d.s2 = q.s1;
        d.tgl_s1 = frame_tgl;
        d.tgl_s2 = q.tgl_s1;
        d.tgl_seen = q.tgl_s2;
        d.trig_prev = trig_s;
        d.start_prev = start_s;

        for (int c = 0; c < 5; c++) begin
            // latched flags: a set in the clearing cycle wins
            d.ots[c] = (q.ots[c] & ~clr[c]) | ots_s[c];
            d.otw[c] = (q.otw[c] & ~clr[c]) | otw_s[c];
            d.olon[c] = (q.olon[c] & ~(clr[c] & ~olraw_s[c])); // [RULE_21]
            d.oloff[c] = q.oloff[c] & ~clr[c]; // [RULE_21]
            d.oc_prev[c] = oc_s[3*c +: 3];
            if (oc_new[c]) begin
                d.oc[c] = oc_s[3*c +: 3]; // [RULE_16]
            end else if (clr[c]) begin
                d.oc[c] = 3'h0;
            end

            // on-state open load, filter only runs while output is high
            if (on_s[c] && olraw_s[c] && !leden_s[c]) begin
                if (q.on_cnt[c] == (dglsel_s[c] ? OLON_LONG_CYC - 19'h1
                                  : OLON_SHORT_CYC - 19'h1)) begin
                    d.olon[c] = 1'b1; // [RULE_17]
                end else begin
                    d.on_cnt[c] = q.on_cnt[c] + 19'h1;
                end
            end else begin
                d.on_cnt[c] = 19'h0;
            end

            // off-state open load window, no restart while running
            if (start_s[c] && !q.start_prev[c] && !q.off_run[c]) begin
                d.off_run[c] = 1'b1;
                d.off_cnt[c] = 18'h0;
                d.dgl_cnt[c] = 10'h0;
            end else if (q.off_run[c]) begin
                d.off_cnt[c] = q.off_cnt[c] + 18'h1;
                d.dgl_cnt[c] = reached_s[c] ? q.dgl_cnt[c] + 10'h1 : 10'h0;
                if (q.dgl_cnt[c] == 10'(`SFR_OLOFF_DGL_CYC - 1)) begin
                    d.off_run[c] = 1'b0; // [RULE_17]
                end else if (q.off_cnt[c] == OLOFF_CYC - 18'h1) begin
                    d.off_run[c] = 1'b0;
                    d.oloff[c] = 1'b1; // [RULE_18]
                end
            end
        end

        // LED open detection at full duty
        case (q.led_st)
            SFR_LED_IDLE: begin
                d.led_cnt = 19'h0;
                if (trig_s && !q.trig_prev) begin
                    d.led_st = SFR_LED_RUN;
                end
            end
            SFR_LED_RUN: begin
                d.led_cnt = q.led_cnt + 19'h1;
                if ((ledcmp_s & leden_s) == 5'h0) begin
                    d.led_st = SFR_LED_IDLE;
                end else if (q.led_cnt == LED_CYC - 19'h1) begin
                    d.led_st = SFR_LED_IDLE; // [RULE_19]
                    d.olon = d.olon | (ledcmp_s & leden_s);
                end
            end
            default: begin
                d.led_st = SFR_LED_IDLE;
            end
        endcase

        // read side effects and address programming at frame end
        if (frame_done) begin
            if (q.sel == `SFR_ADDR_QUICK) begin
                d.registers_cleared_flag = 1'b0;
            end
            if (init_wr) begin
                d.persist = rx_word[`SFR_PERSIST_BIT];
                d.sel = rx_word[`SFR_SOA_MSB:`SFR_SOA_LSB]; // [RULE_03]
                if (d.sel == `SFR_ADDR_INIT1) begin
                    d.sel = `SFR_ADDR_QUICK; // [RULE_06]
                end
            end else if (!q.persist) begin
                d.sel = `SFR_ADDR_QUICK; // [RULE_04]
            end
        end

        // readout word, frozen while a frame is selected
        if (cs_s) begin
            if (q.sel == `SFR_ADDR_QUICK) begin
                d.tx = {`SFR_ADDR_QUICK, fm_s, device_summary_flag, overload_summary_flag, openload_summary_flag, cp_s,
                        q.registers_cleared_flag, clock_fail_flag_s, qsf}; // [RULE_12]
            end else if (q.sel >= `SFR_ADDR_CH_FIRST &&
                         q.sel <= `SFR_ADDR_CH_LAST) begin
                d.tx = chan_word(q.sel, {fm_s, device_summary_flag, overload_summary_flag, openload_summary_flag},
                    q.ots[3'(q.sel - `SFR_ADDR_CH_FIRST)],
                    q.otw[3'(q.sel - `SFR_ADDR_CH_FIRST)],
                    q.oc[3'(q.sel - `SFR_ADDR_CH_FIRST)],
                    q.olon[3'(q.sel - `SFR_ADDR_CH_FIRST)],
                    q.oloff[3'(q.sel - `SFR_ADDR_CH_FIRST)]); // [RULE_15]
            end else begin
                d.tx = {q.sel, fm_s, 11'h0}; // [RULE_22]
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            q <= '0;
            q.sel <= `SFR_SEL_RST;
            q.persist <= `SFR_PERSIST_RST;
            q.registers_cleared_flag <= `SFR_RCF_RST; // [RULE_11]
            q.led_st <= SFR_LED_IDLE;
        end else begin
            q <= d;
        end
    end

    // live comparator level, meaningless while undervoltage is set
    assign O_OUTPUT_LEVEL = half_s; // [RULE_01] [RULE_02]
    assign O_OPEN_OFF_ACTIVE = q.off_run;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_N);

    a_sel_single_shot: assert property ( // [RULE_04]
        frame_done && !init_wr && !q.persist |=> q.sel == `SFR_ADDR_QUICK)
        else $error("single-shot address did not revert");

    a_sel_persist_hold: assert property ( // [RULE_05]
        frame_done && !init_wr && q.persist |=> $stable(q.sel))
        else $error("persistent address changed without a write");

    a_sel_program_new: assert property ( // [RULE_03]
        frame_done && init_wr && rx_word[3:0] != 4'h0
        |=> q.sel == $past(rx_word[3:0]))
        else $error("programmed address not taken");

    a_quick_nibble_one: assert property ( // [RULE_06]
        cs_s && q.sel == `SFR_ADDR_QUICK |=> q.tx[15:12] == 4'h1)
        else $error("quick word address nibble wrong");

    a_fail_mode_bit: assert property ( // [RULE_07]
        cs_s |=> q.tx[`SFR_FM_BIT] == $past(fm_s))
        else $error("fail-mode bit missing from word");

    a_device_flag_or: assert property ( // [RULE_09]
        cs_s && q.sel == `SFR_ADDR_QUICK
        |=> q.tx[`SFR_DSF_BIT] == $past(device_summary_flag))
        else $error("device summary flag wrong");

    a_oc_newest_code: assert property ( // [RULE_16]
        oc_new[0] |=> q.oc[0] == $past(oc_s[2:0]))
        else $error("newest overcurrent code not kept");

    a_oloff_window_end: assert property ( // [RULE_18]
        q.off_run[0] && q.off_cnt[0] == OLOFF_CYC - 18'h1 &&
        q.dgl_cnt[0] != 10'(`SFR_OLOFF_DGL_CYC - 1)
        |=> q.oloff[0] && !q.off_run[0])
        else $error("off-state window end did not report");

    a_olon_clear_held: assert property ( // [RULE_21]
        clr[0] && q.olon[0] && olraw_s[0] |=> q.olon[0])
        else $error("open-load cleared while condition present");

    a_ots_overload: assert property ( // [RULE_10]
        q.ots != 5'h0 |-> overload_summary_flag)
        else $error("overload flag missing shutdown source");

endmodule : sfr_fault_readout

// file: sfr_host_model.sv
// serial host model driving sixteen-bit frames into the readout
`timescale 1ns/1ps

module sfr_host_model (
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end

    // ****************************************************************
    // one whole frame
    // ****************************************************************
    // serial clock runs only inside the frame, 30 ns period
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        #7.3;
        o_sdi = tx[15];
        o_cs_n = 1'b0;
        #15;
        for (int i = 15; i >= 0; i--) begin
            // an undriven line must never pass for data
            rx[i] = i_sdo_oe ? i_sdo : 1'bx;
            o_sclk = 1'b1;
            #15;
            o_sclk = 1'b0;
            o_sdi = (i > 0) ? tx[i-1] : ~tx[0];
            #15;
        end
        o_cs_n = 1'b1;
        #100;
    endtask : xfer
endmodule : sfr_host_model

// file: sfr_fault_readout_tb_top.sv
// self-checking testbench of the fault readout
`timescale 1ns/1ps

module sfr_fault_readout_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fm = 1'b0;
    logic [4:0] dev_q = 5'h00;
    logic [4:0] ots = 5'h00;
    logic [4:0] otw = 5'h00;
    logic [14:0] oc = 15'h0000;
    logic [4:0] on_raw = 5'h00;
    logic [4:0] out_on = 5'h00;
    logic [4:0] dgl_sel = 5'h00;
    logic [4:0] off_start = 5'h00;
    logic [4:0] off_reached = 5'h00;
    logic [4:0] led_en = 5'h00;
    logic [4:0] led_cmp = 5'h00;
    logic led_trig = 1'b0;
    logic [4:0] hs_cmp = 5'h00;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic [4:0] lvl;
    logic [4:0] off_act;
    int error_cnt = 0;
    int n_compared = 0;

    always #2.5 clk = ~clk;

    sfr_fault_readout #(
        .OLON_SHORT_CYC(19'h14),
        .OLON_LONG_CYC(19'h28),
        .OLOFF_CYC(18'h3c),
        .LED_CYC(19'h32)
    ) dut_u (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk),
        .I_CS_N(cs_n), .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(sdo_oe),
        .I_FAIL_MODE(fm), .I_UNDERVOLT(dev_q[0]),
        .I_OVERVOLT(dev_q[1]), .I_PUMP_FAULT(dev_q[2]),
        .I_CLOCK_FAIL(dev_q[3]), .I_TEST_ACTIVE(dev_q[4]),
        .I_OVERTEMP_SHUTDOWN(ots), .I_OVERTEMP_WARN(otw),
        .I_OC_CODE(oc), .I_OPEN_ON_RAW(on_raw), .I_OUTPUT_ON(out_on),
        .I_OPEN_ON_DEGLITCH_SEL(dgl_sel), .I_OPEN_OFF_START(off_start),
        .I_OFF_CURRENT_REACHED(off_reached), .I_LED_OPEN_DETECT(led_en),
        .I_LED_CMP(led_cmp), .I_LED_TRIGGER(led_trig),
        .I_HALF_SUPPLY_CMP(hs_cmp), .O_OUTPUT_LEVEL(lvl),
        .O_OPEN_OFF_ACTIVE(off_act)
    );

    sfr_host_model host_u (
        .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_sdi(sdi)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one frame; f000 is a write to nothing, so a pure read
    task automatic xf(input logic [15:0] tx, input logic [15:0] exp,
                      input string what);
        logic [15:0] r;
        host_u.xfer(tx, r);
        chk(r, exp, what);
    endtask : xf

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_quick();
        xf(16'hf000, 16'h1440, "cleared flag after reset");
        xf(16'hf000, 16'h1000, "quick idle");
        @(posedge clk);
        fm <= 1'b1;
        cyc(4);
        xf(16'hf000, 16'h1800, "fail mode");
        @(posedge clk);
        fm <= 1'b0;
        $display("t_quick done");
    endtask : t_quick

    task automatic t_device();
        logic [15:0] e;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            dev_q <= 5'h01 << i;
            cyc(4);
            e = 16'h1400 | ((i == 2) ? 16'h0080 : 16'h0000);
            e = e | ((i == 3) ? 16'h0020 : 16'h0000);
            xf(16'hf000, e, "device flag");
        end
        @(posedge clk);
        dev_q <= 5'h00;
        cyc(4);
        $display("t_device done");
    endtask : t_device

    task automatic t_channel();
        @(posedge clk);
        oc[8:6] <= 3'h2;
        cyc(4);
        oc[8:6] <= 3'h5;
        cyc(4);
        oc[8:6] <= 3'h0;
        cyc(4);
        xf(16'hf000, 16'h1204, "overcurrent quick");
        xf(16'h0004, 16'h1204, "select ch3");
        xf(16'hf000, 16'h4214, "ch3 word");
        xf(16'hf000, 16'h1000, "back to quick");
        $display("t_channel done");
    endtask : t_channel

    task automatic t_openoff();
        int n;
        n = 0;
        @(posedge clk);
        off_start <= 5'h01;
        while (off_act[0] !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (off_act[0] === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n >= 59 && n <= 61), 16'h0001, "off window");
        @(posedge clk);
        off_start <= 5'h00;
        cyc(4);
        xf(16'hf000, 16'h1101, "open quick");
        xf(16'h0002, 16'h1101, "select ch1");
        xf(16'hf000, 16'h2101, "ch1 word");
        xf(16'hf000, 16'h1000, "open cleared");
        $display("t_openoff done");
    endtask : t_openoff

    task automatic t_level();
        logic [4:0] v [2] = '{5'h15, 5'h0a};
        foreach (v[k]) begin
            @(posedge clk);
            hs_cmp <= v[k];
            cyc(5);
            @(negedge clk);
            chk({11'h000, lvl}, {11'h000, v[k]}, "level");
        end
        $display("t_level done");
    endtask : t_level

    // on-state open load, read while still open, then after it has gone
    task automatic t_openon();
        @(posedge clk);
        out_on[0] <= 1'b1;
        on_raw[0] <= 1'b1;
        cyc(30);
        xf(16'h0002, 16'h1101, "open on quick");
        xf(16'hf000, 16'h2102, "ch1 open on");
        xf(16'hf000, 16'h1101, "open on held");
        @(posedge clk);
        on_raw[0] <= 1'b0;
        out_on[0] <= 1'b0;
        cyc(4);
        xf(16'h0002, 16'h1101, "reselect ch1");
        xf(16'hf000, 16'h2102, "ch1 open on again");
        xf(16'hf000, 16'h1000, "open on cleared");
        $display("t_openon done");
    endtask : t_openon

    // full-duty LED check with the comparator held open
    task automatic t_led();
        @(posedge clk);
        led_en[1] <= 1'b1;
        led_cmp[1] <= 1'b1;
        led_trig <= 1'b1;
        cyc(70);
        led_trig <= 1'b0;
        led_cmp[1] <= 1'b0;
        xf(16'h0003, 16'h1102, "led quick");
        xf(16'hf000, 16'h3102, "ch2 led open");
        $display("t_led done");
    endtask : t_led

    task automatic t_persist();
        @(posedge clk);
        ots[4] <= 1'b1;
        cyc(4);
        xf(16'h0016, 16'h1210, "select ch5 persist");
        xf(16'hf000, 16'h6240, "ch5 first");
        xf(16'hf000, 16'h6240, "ch5 again");
        xf(16'h0000, 16'h6240, "select zero");
        xf(16'hf000, 16'h1210, "address zero");
        $display("t_persist done");
    endtask : t_persist

    // ****************************************************************
    // sequence and watchdog
    // ****************************************************************
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(8);
        t_quick();
        t_device();
        t_channel();
        t_openoff();
        t_level();
        t_openon();
        t_led();
        t_persist();
        print_verdict();
    end

    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : sfr_fault_readout_tb_top
